// ==== common/pfd_defs.svh ====
// Constants of the power-failure deceleration control block
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH
// Register word indexes
`define PFD_REG_MODE     4'h0
`define PFD_REG_DROP     4'h1
`define PFD_REG_THRESH   4'h2
`define PFD_REG_TIME1    4'h3
`define PFD_REG_TIME2    4'h4
`define PFD_REG_SWITCH   4'h5
`define PFD_REG_COAST    4'h6
`define PFD_REG_CONFIG   4'h7
`define PFD_REG_REFFREQ  4'h8
`define PFD_REG_STATUS   4'h9
`define PFD_REG_OUTFREQ  4'hA
// Config bit positions
`define PFD_CFG_PHASE    0
`define PFD_CFG_INCR     1
// Mode codes
`define PFD_MODE_COAST   8'h00
`define PFD_MODE_STOP    8'h01
`define PFD_MODE_CONT    8'h02
`define PFD_MODE_ASTOP   8'h15
`define PFD_MODE_ACONT   8'h16
// Disabled-setting sentinel (9999)
`define PFD_OFF          16'h270F
// Reset values, frequencies in 0.1 Hz, times in increments
`define PFD_RST_DROP     16'h001E
`define PFD_RST_THRESH   16'h01F4
`define PFD_RST_TIME1    16'h0032
`define PFD_RST_SWITCH   16'h01F4
`define PFD_RST_REFFREQ  16'h0258
// Limits
`define PFD_MAX_DROP     16'h00C8
`define PFD_MAX_THRESH   16'h04B0
`define PFD_MAX_SWITCH   16'h0FA0
`define PFD_MAX_TIME_0   16'h8CA0
`define PFD_MAX_TIME_1   16'h8CA0
// Control ticks per time increment: 0.1 s and 0.01 s at 1 ms
`define PFD_TICKS_INC0   8'h64
`define PFD_TICKS_INC1   8'h0A
// Fixed slope time used by the automatic modes, 0.1 s units
`define PFD_AUTO_TIME    16'h0014
// Control tick period and core clock period
`define PFD_TICK_NS      1000000
`define PFD_CLK_NS       10
`endif

// ==== common/pfd_pkg.sv ====
// Types of the power-failure deceleration control block
package pfd_pkg;
  typedef enum logic [5:0] {
    PFD_IDLE    = 6'b000001,
    PFD_RUN     = 6'b000010,
    PFD_DECEL   = 6'b000100,
    PFD_FSTOP   = 6'b001000,
    PFD_COAST   = 6'b010000,
    PFD_RESTART = 6'b100000
  } pfd_state_t;
endpackage

// ==== rtl/pfd_core.sv ====
// Power-failure deceleration control with Avalon-MM register slave
//
// What this block does
// - Nonzero mode ramps to stop; mode 0 coasts
// - Modes 21, 22 choose ramp time automatically
// - Onset drops output by drop setting
// - Drop only at or above threshold
// - Slope one from time one, reference
// - Time two below switchover; 9999 keeps one
// - Slope switches at the switchover frequency
// - Increment select scales both decel times
// - Mode 1 ramps to stop despite restoration
// - Restart selected overrides mode 1 stop
// - Start held at power-up is refused
// - Mode 2 re-accelerates when supply returns
// - Mode 2 standstill restoration runs restart
// - Negative result is zero with DC brake
// - Status output during and after failure ramp
// - Automatic modes ignore the ramp settings
`timescale 1ns/100ps
`include "pfd_defs.svh"
module pfd_core
  import pfd_pkg::*;
#(
  parameter int P_TICK_CYCLES = `PFD_TICK_NS / `PFD_CLK_NS
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Supply monitor
  input  wire logic        i_undervoltage,
  input  wire logic        i_power_fail,
  input  wire logic        i_phase_loss,
  input  wire logic        i_supply_restored,
  // Operator and speed command
  input  wire logic        i_forward_start_cmd,
  input  wire logic        i_reverse_start_cmd,
  input  wire logic [15:0] i_set_freq,
  // Drive outputs
  output logic      [15:0] o_out_freq,
  output logic             o_output_enable,
  output logic             o_dc_brake,
  output logic             o_restart_req,
  output logic             o_auto_decel,
  output logic             o_failure_decel_status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0]  mode_ff;
  logic [15:0] drop_ff;
  logic [15:0] thresh_ff;
  logic [15:0] time1_ff;
  logic [15:0] time2_ff;
  logic [15:0] switch_ff;
  logic [15:0] coast_ff;
  logic [1:0]  cfg_ff;
  logic [15:0] ref_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  pfd_state_t  state_ff;
  pfd_state_t  nxt_state;
  logic [15:0] freq_ff;
  logic [31:0] acc_ff;
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;
  logic        armed_ff;
  logic        brake_ff;

  logic        wr_en;
  logic [15:0] wdata;
  logic [15:0] time_max;
  logic        fail_ev;
  logic        start_cmd;
  logic        start_ok;
  logic        auto_mode;
  logic        restart_sel;
  logic        cont_mode;
  logic        drop_apply;
  logic [15:0] time_sel;
  logic [7:0]  ticks_per_inc;
  logic [31:0] den;

  assign wr_en       = i_avs_write && !wait_ff;
  assign wdata       = i_avs_writedata[15:0];
  assign time_max    = cfg_ff[`PFD_CFG_INCR] ? `PFD_MAX_TIME_1 : `PFD_MAX_TIME_0;
  assign start_cmd   = i_forward_start_cmd || i_reverse_start_cmd;
  assign start_ok    = armed_ff && start_cmd;
  assign auto_mode   = (mode_ff == `PFD_MODE_ASTOP) || (mode_ff == `PFD_MODE_ACONT);
  assign cont_mode   = (mode_ff == `PFD_MODE_CONT) || (mode_ff == `PFD_MODE_ACONT);
  assign restart_sel = (coast_ff != `PFD_OFF);
  // Phase loss counts only when its protection is selected
  assign fail_ev     = i_undervoltage || i_power_fail
                       || (i_phase_loss && cfg_ff[`PFD_CFG_PHASE]);
  assign drop_apply  = !auto_mode && ((thresh_ff == `PFD_OFF) || (freq_ff >= thresh_ff));

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then a single accept edge
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_ff <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && wait_ff) begin
      unique case (i_avs_address)
        `PFD_REG_MODE:    rdata_ff <= {24'h00_0000, mode_ff};
        `PFD_REG_DROP:    rdata_ff <= {16'h0000, drop_ff};
        `PFD_REG_THRESH:  rdata_ff <= {16'h0000, thresh_ff};
        `PFD_REG_TIME1:   rdata_ff <= {16'h0000, time1_ff};
        `PFD_REG_TIME2:   rdata_ff <= {16'h0000, time2_ff};
        `PFD_REG_SWITCH:  rdata_ff <= {16'h0000, switch_ff};
        `PFD_REG_COAST:   rdata_ff <= {16'h0000, coast_ff};
        `PFD_REG_CONFIG:  rdata_ff <= {30'h0000_0000, cfg_ff};
        `PFD_REG_REFFREQ: rdata_ff <= {16'h0000, ref_ff};
        `PFD_REG_STATUS:  rdata_ff <= {21'h00_0000, armed_ff, brake_ff,
                                       o_failure_decel_status_out, 2'b00, state_ff};
        `PFD_REG_OUTFREQ: rdata_ff <= {16'h0000, freq_ff};
        default:          rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Writes outside a setting's range, and unlisted modes, are ignored
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff   <= `PFD_MODE_COAST;
      drop_ff   <= `PFD_RST_DROP;
      thresh_ff <= `PFD_RST_THRESH;
      time1_ff  <= `PFD_RST_TIME1;
      time2_ff  <= `PFD_OFF;
      switch_ff <= `PFD_RST_SWITCH;
      coast_ff  <= `PFD_OFF;
      cfg_ff    <= 2'b00;
      ref_ff    <= `PFD_RST_REFFREQ;
    end else if (wr_en) begin
      unique case (i_avs_address)
        `PFD_REG_MODE: begin
          if (wdata[15:8] == 8'h00 && (wdata[7:0] == `PFD_MODE_COAST || wdata[7:0] == `PFD_MODE_STOP
              || wdata[7:0] == `PFD_MODE_CONT || wdata[7:0] == `PFD_MODE_ASTOP
              || wdata[7:0] == `PFD_MODE_ACONT)) begin
            mode_ff <= wdata[7:0];
          end
        end
        `PFD_REG_DROP: begin
          if (wdata <= `PFD_MAX_DROP) drop_ff <= wdata;
        end
        `PFD_REG_THRESH: begin
          if (wdata <= `PFD_MAX_THRESH || wdata == `PFD_OFF) thresh_ff <= wdata;
        end
        `PFD_REG_TIME1: begin
          if (wdata <= time_max) time1_ff <= wdata;
        end
        `PFD_REG_TIME2: begin
          if (wdata <= time_max || wdata == `PFD_OFF) time2_ff <= wdata;
        end
        `PFD_REG_SWITCH: begin
          if (wdata <= `PFD_MAX_SWITCH) switch_ff <= wdata;
        end
        `PFD_REG_COAST:   coast_ff  <= wdata;
        `PFD_REG_CONFIG:  cfg_ff    <= i_avs_writedata[1:0];
        `PFD_REG_REFFREQ: ref_ff    <= wdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control tick divider
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 32'(P_TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slope selection
  always_comb begin
    ticks_per_inc = cfg_ff[`PFD_CFG_INCR] ? `PFD_TICKS_INC1 : `PFD_TICKS_INC0;
    if (auto_mode) begin
      time_sel      = `PFD_AUTO_TIME;
      ticks_per_inc = `PFD_TICKS_INC0;
    end else if (freq_ff < switch_ff && time2_ff != `PFD_OFF) begin
      time_sel = time2_ff;
    end else begin
      time_sel = time1_ff;
    end
    den = {16'h0000, time_sel} * {24'h00_0000, ticks_per_inc};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start interlock: a start must be seen low before it counts
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_ff <= 1'b0;
    end else if (!start_cmd) begin
      armed_ff <= 1'b1;
    end else if (state_ff == PFD_IDLE || state_ff == PFD_FSTOP) begin
      armed_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PFD_IDLE: begin
        if (start_ok && !fail_ev) nxt_state = PFD_RUN;
      end
      PFD_RUN: begin
        if (fail_ev) begin
          if (mode_ff == `PFD_MODE_COAST) begin
            nxt_state = PFD_COAST;
          end else if (restart_sel && !cont_mode) begin
            nxt_state = PFD_RESTART;
          end else if (drop_apply && freq_ff <= drop_ff) begin
            nxt_state = PFD_FSTOP;
          end else begin
            nxt_state = PFD_DECEL;
          end
        end else if (!start_cmd) begin
          nxt_state = PFD_IDLE;
        end
      end
      PFD_DECEL: begin
        if (cont_mode && i_supply_restored && !fail_ev) begin
          nxt_state = PFD_RUN;
        end else if (freq_ff == 16'h0000) begin
          nxt_state = PFD_FSTOP;
        end
      end
      PFD_FSTOP: begin
        if (cont_mode && restart_sel && i_supply_restored && !fail_ev) begin
          nxt_state = PFD_RESTART;
        end else if (start_ok && !fail_ev) begin
          nxt_state = PFD_RUN;
        end
      end
      PFD_COAST: begin
        if (!start_cmd) nxt_state = PFD_IDLE;
      end
      PFD_RESTART: begin
        if (i_supply_restored && !fail_ev) nxt_state = PFD_RUN;
      end
      default: nxt_state = PFD_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= PFD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp generator: tick adds the reference, each non-tick clock spends at most one slope step
  // Stepping per clock avoids a divider but caps steep slopes at one step per non-tick clock
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      freq_ff <= 16'h0000;
      acc_ff  <= 32'h0000_0000;
    end else if (state_ff == PFD_RUN && nxt_state == PFD_DECEL) begin
      acc_ff <= 32'h0000_0000;
      if (drop_apply) freq_ff <= freq_ff - drop_ff;
    end else if (nxt_state == PFD_FSTOP) begin
      // Zero together with the brake so braking never meets a running output
      freq_ff <= 16'h0000;
      acc_ff  <= 32'h0000_0000;
    end else if (state_ff == PFD_DECEL || state_ff == PFD_RUN) begin
      if (state_ff == PFD_DECEL && den == 32'h0000_0000) begin
        freq_ff <= 16'h0000;
      end else if (tick_ff) begin
        acc_ff <= acc_ff + {16'h0000, ref_ff};
      end else if (acc_ff >= den && den != 32'h0000_0000) begin
        acc_ff <= acc_ff - den;
        if (state_ff == PFD_DECEL && freq_ff != 16'h0000) begin
          freq_ff <= freq_ff - 16'h0001;
        end else if (state_ff == PFD_RUN && freq_ff < i_set_freq) begin
          freq_ff <= freq_ff + 16'h0001;
        end else if (state_ff == PFD_RUN && freq_ff > i_set_freq) begin
          freq_ff <= freq_ff - 16'h0001;
        end else begin
          acc_ff <= 32'h0000_0000;
        end
      end
    end else begin
      freq_ff <= 16'h0000;
      acc_ff  <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DC brake holds while stopped after a failure ramp
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      brake_ff <= 1'b0;
    end else begin
      brake_ff <= (nxt_state == PFD_FSTOP);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_output_enable            <= 1'b0;
      o_restart_req              <= 1'b0;
      o_auto_decel               <= 1'b0;
      o_failure_decel_status_out <= 1'b0;
    end else begin
      o_output_enable            <= (state_ff == PFD_RUN) || (state_ff == PFD_DECEL);
      o_restart_req              <= (state_ff == PFD_RESTART);
      o_auto_decel               <= auto_mode && (state_ff == PFD_DECEL);
      o_failure_decel_status_out <= (state_ff == PFD_DECEL) || (state_ff == PFD_FSTOP);
    end
  end

  assign o_out_freq        = freq_ff;
  assign o_dc_brake        = brake_ff;
  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

endmodule

// ==== test/pfd_core_sva.sv ====
// Assertion checker for the power-failure deceleration block
`timescale 1ns/100ps
module pfd_core_chk (
  // Clock, reset and register bus
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Supply monitor and operator
  input wire logic        i_undervoltage,
  input wire logic        i_power_fail,
  input wire logic        i_phase_loss,
  input wire logic        i_supply_restored,
  input wire logic        i_forward_start_cmd,
  input wire logic        i_reverse_start_cmd,
  // Drive outputs
  input wire logic [15:0] o_out_freq,
  input wire logic        o_output_enable,
  input wire logic        o_dc_brake,
  input wire logic        o_restart_req,
  input wire logic        o_auto_decel,
  input wire logic        o_failure_decel_status_out
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  bus_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus wait not one cycle");
  bus_hole_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > 4'hA |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  stat_cause_a: assert property ($rose(o_failure_decel_status_out) |-> $past(i_undervoltage || i_power_fail || i_phase_loss, 2))
    else $error("status rose without failure");
  // Guarded by restoration: mode 2 may climb again once supply is back
  decel_step_a: assert property (o_failure_decel_status_out && $past(o_failure_decel_status_out) && !i_supply_restored
    |-> o_out_freq <= $past(o_out_freq) && $past(o_out_freq) - o_out_freq <= 16'h0001) else $error("bad ramp step");
  brake_zero_a: assert property (o_dc_brake |-> o_out_freq == 16'h0000)
    else $error("brake with nonzero frequency");
  auto_stat_a: assert property ($rose(o_auto_decel) |-> ##[0:2] o_failure_decel_status_out)
    else $error("auto ramp without status");
  start_need_a: assert property ($rose(o_output_enable) |-> $past(i_forward_start_cmd || i_reverse_start_cmd))
    else $error("output enabled without start");
  restart_excl_a: assert property (o_restart_req |-> !o_failure_decel_status_out)
    else $error("restart and failure status together");
  fail_react_a: assert property (o_output_enable && (i_undervoltage || i_power_fail)
    |-> ##[1:3] (o_failure_decel_status_out || o_restart_req || !o_output_enable)) else $error("failure ignored");
  cover property ($rose(o_failure_decel_status_out));
  cover property ($rose(o_restart_req));
  cover property ($rose(o_dc_brake));
  cover property ($rose(o_auto_decel));
endmodule
bind pfd_core pfd_core_chk pfd_core_chk_i (.*);

// ==== test/pfd_mains_model.sv ====
// Mains supply model feeding the supply monitor levels
`timescale 1ns/100ps
module pfd_mains_model (
  // Clock, reset and bench control
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_kind,
  input  wire logic       i_fault,
  // Supply monitor levels
  output logic            o_uv,
  output logic            o_pf,
  output logic            o_pl,
  output logic            o_ok
);
  // Levels move only on the edge; kind 0 undervoltage, 1 power loss, 2 phase loss
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_uv <= 1'b0;
      o_pf <= 1'b0;
      o_pl <= 1'b0;
      o_ok <= 1'b1;
    end else begin
      o_uv <= i_fault && i_kind == 2'h0;
      o_pf <= i_fault && i_kind == 2'h1;
      o_pl <= i_fault && i_kind == 2'h2;
      o_ok <= !i_fault;
    end
  end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the power-failure deceleration block
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, arst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, fwd = 1'b1, flt = 1'b0, seen_rr = 1'b0;
  logic        pl_cfg = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] set_f = 16'h0000, t2 = 16'h270F;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, q;
  logic [15:0] freq, f, d;
  logic        wait_r, en, brake, rst_req, auto_d, stat, uv, pf, pl, ok;
  int          n_errors = 0, n_tests = 0, cyc = 0, i, e, seed = 32'h196b;
  logic [31:0] rst_tab [12] = '{0, 'h1E, 'h1F4, 'h32, 'h270F, 'h1F4, 'h270F, 0, 'h258, 1, 0, 0};
  pfd_core #(.P_TICK_CYCLES(10)) pfd_core_i (.i_core_clk(clk), .i_arst_n(arst_n), .i_avs_address(addr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_undervoltage(uv), .i_power_fail(pf), .i_phase_loss(pl), .i_supply_restored(ok),
    .i_forward_start_cmd(fwd), .i_reverse_start_cmd(1'b0), .i_set_freq(set_f), .o_out_freq(freq),
    .o_output_enable(en), .o_dc_brake(brake), .o_restart_req(rst_req), .o_auto_decel(auto_d),
    .o_failure_decel_status_out(stat));
  pfd_mains_model pfd_mains_model_i (.i_clk(clk), .i_rst_n(arst_n), .i_kind(kind), .i_fault(flt), .o_uv(uv),
    .o_pf(pf), .o_pl(pl), .o_ok(ok));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (rst_req === 1'b1) seen_rr <= 1'b1;
  // Ceiling well above the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    wr_s <= w;
    rd_s <= !w;
    // Only the bench timeout ends a wait that never answers
    do begin
      @(posedge clk);
    end while (wait_r !== 1'b0);
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  task automatic wait_f(input logic [15:0] t);
    int k;
    k = 0;
    while (freq !== t && k < 4000) begin
      @(posedge clk);
      k++;
    end
    check(freq, t);
  endtask
  function automatic logic [31:0] exp_drop(input logic [7:0] m, input logic [15:0] fr, dr, th);
    if (m > 8'h02) return 32'h0000_0001;
    if (th != 16'h270F && fr < th) return 32'h0000_0001;
    if (fr <= dr) return {16'h0000, fr};
    return {16'h0000, dr};
  endfunction
  function automatic int exp_steps(input int cycles, input int tm, input int tpi);
    return (cycles / 10) * 600 / (tm * tpi);
  endfunction
  // Run up to fr, fail the supply, then check the first frequency change
  task automatic fail_run(input logic [7:0] m, input logic [1:0] k, input logic [15:0] fr, dr, th, co, input logic s);
    logic [15:0] f0;
    int n;
    flt <= 1'b0;
    bus(1'b1, 4'h0, {24'h00_0000, m});
    bus(1'b1, 4'h1, {16'h0000, dr});
    bus(1'b1, 4'h2, {16'h0000, th});
    bus(1'b1, 4'h6, {16'h0000, co});
    set_f <= fr;
    fwd <= 1'b0;
    repeat (3) @(posedge clk);
    fwd <= 1'b1;
    wait_f(fr);
    // Slope two is loaded only at speed so a slow setting cannot stall the run-up
    bus(1'b1, 4'h4, {16'h0000, t2});
    f0 = freq;
    kind <= k;
    flt <= 1'b1;
    if (m != 8'h00 && (k != 2'h2 || pl_cfg) && (co == 16'h270F || m == 8'h02 || m == 8'h16)) begin
      n = 0;
      while (freq === f0 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      check({16'h0000, f0 - freq}, exp_drop(m, f0, dr, th));
      if (s) wait_f(16'h0000);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 12; i++) rchk(4'(i), rst_tab[i]);
    check(en, 1'b0);
    bus(1'b1, 4'h0, 32'h0000_0003);
    rchk(4'h0, 32'h0000_0000);
    bus(1'b1, 4'h1, 32'h0000_00C9);
    rchk(4'h1, 32'h0000_001E);
    bus(1'b1, 4'h7, 32'h0000_0002);
    bus(1'b1, 4'h3, 32'h0000_0005);
    for (i = 0; i < 3; i++) begin
      f = 16'h0190 + 16'({$random(seed)} % 600);
      d = 16'h0001 + 16'({$random(seed)} % 200);
      fail_run(8'h01, 2'(i % 2), f, d, 16'h01F4, 16'h270F, 1'b1);
      repeat (3) @(posedge clk);
      check({en, brake, stat}, 3'b011);
      flt <= 1'b0;
      repeat (20) @(posedge clk);
      check({en, stat}, 2'b01);
    end
    fail_run(8'h01, 2'h1, 16'h01C2, 16'h001E, 16'h270F, 16'h270F, 1'b1);
    fail_run(8'h01, 2'h1, 16'h0014, 16'h001E, 16'h270F, 16'h270F, 1'b0);
    repeat (3) @(posedge clk);
    check(brake, 1'b1);
    fail_run(8'h01, 2'h2, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b0);
    repeat (10) @(posedge clk);
    check({stat, freq}, {1'b0, 16'h0258});
    flt <= 1'b0;
    pl_cfg = 1'b1;
    bus(1'b1, 4'h7, 32'h0000_0003);
    fail_run(8'h01, 2'h2, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b1);
    fail_run(8'h00, 2'h1, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b0);
    repeat (5) @(posedge clk);
    check({en, stat}, 2'b00);
    fail_run(8'h02, 2'h0, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b0);
    repeat (50) @(posedge clk);
    flt <= 1'b0;
    wait_f(16'h0258);
    repeat (3) @(posedge clk);
    check(stat, 1'b0);
    seen_rr <= 1'b0;
    fail_run(8'h02, 2'h1, 16'h0064, 16'h001E, 16'h270F, 16'h000A, 1'b1);
    flt <= 1'b0;
    wait_f(16'h0064);
    check(seen_rr, 1'b1);
    seen_rr <= 1'b0;
    fail_run(8'h01, 2'h1, 16'h0258, 16'h001E, 16'h01F4, 16'h000A, 1'b0);
    repeat (10) @(posedge clk);
    check({stat, seen_rr}, 2'b01);
    flt <= 1'b0;
    wait_f(16'h0258);
    for (i = 0; i < 2; i++) begin
      fail_run(i ? 8'h16 : 8'h15, 2'h1, 16'h0028, 16'h00C8, 16'h01F4, 16'h270F, 1'b0);
      repeat (2) @(posedge clk);
      check(auto_d, 1'b1);
      wait_f(16'h0000);
    end
    // Slope two is made very slow so the switchover point is easy to see
    t2 = 16'h03E8;
    fail_run(8'h01, 2'h1, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b0);
    repeat (300) @(posedge clk);
    check(freq <= 16'h01F4 && freq >= 16'h01EF, 1'b1);
    t2 = 16'h270F;
    bus(1'b1, 4'h4, 32'h0000_270F);
    bus(1'b1, 4'h5, 32'h0000_0000);
    wait_f(16'h0000);
    fail_run(8'h01, 2'h1, 16'h0258, 16'h001E, 16'h01F4, 16'h270F, 1'b0);
    f = freq;
    bus(1'b1, 4'h7, 32'h0000_0000);
    repeat (200) @(posedge clk);
    e = exp_steps(200, 5, 100);
    check(f - freq >= e - 2 && f - freq <= e + 6, 1'b1);
    bus(1'b1, 4'h7, 32'h0000_0002);
    wait_f(16'h0000);
    give_verdict();
  end
endmodule
